// ---- include/cpd_pkg.sv ----
`default_nettype none
package cpd_pkg;
	localparam int WORD_W = 8;
	localparam int TOP_HI = 7;
	localparam int TOP_LO = 6;
	localparam int SEL_HI = 5;
	localparam int SEL_LO = 4;
	localparam int NIB_HI = 3;
	localparam int NIB_LO = 0;
	localparam int LOW_HI = 1;
	localparam int LOW_LO = 0;
	localparam int SUB_HI = 3;
	localparam int SUB_LO = 2;
	localparam int ADDR_W = 6;
	localparam logic [1:0] TOP_REG = 2'h0;
	localparam logic [1:0] TOP_BIT = 2'h1;
	localparam logic [1:0] TOP_CALL = 2'h2;
	localparam logic [1:0] TOP_JUMP = 2'h3;
	localparam logic [1:0] SEL_0 = 2'h0;
	localparam logic [1:0] SEL_1 = 2'h1;
	localparam logic [1:0] SEL_2 = 2'h2;
	localparam logic [1:0] SEL_3 = 2'h3;
	localparam logic [3:0] NIB_ACC = 4'h0;
	localparam logic [3:0] NIB_HOLD = 4'h1;
	localparam logic [3:0] NIB_ARITH = 4'h2;
	localparam logic [3:0] NIB_CARRY = 4'h3;
	localparam logic [3:0] NIB_FLAG = 4'h4;
	localparam logic [3:0] NIB_TEST = 4'h5;
	localparam logic [3:0] NIB_MTA = 4'h6;
	localparam logic [3:0] NIB_SWAP = 4'h7;
	localparam logic [3:0] NIB_SWAP_DEC = 4'h8;
	localparam logic [3:0] NIB_SWAP_INC = 4'h9;
	localparam logic [3:0] NIB_LB_PROG = 4'ha;
	localparam logic [3:0] LB_PROG_MAX = 4'ha;
	localparam logic [3:0] LB_PROG_DEF = 4'h0;
	localparam logic [3:0] MASK_1 = 4'h1;
	localparam logic [3:0] MASK_2 = 4'h2;
	localparam logic [3:0] MASK_4 = 4'h4;
	localparam logic [3:0] MASK_8 = 4'h8;
	localparam logic [3:0] ZERO_NIB = 4'h0;

	typedef enum logic [5:0] {
		OP_NOP,
		OP_SHOW_ACC_BCD_SEGMENTS,
		OP_INVERT_ACCUMULATOR,
		OP_CLEAR_ACCUMULATOR,
		OP_SWAP_HOLD_WITH_ROW_POINTER,
		OP_SHOW_ACC_DECODED_SEGMENTS,
		OP_SERIAL_SHIFT_EXCHANGE,
		OP_SWAP_HOLD_AND_ACC,
		OP_ADD_WITH_CARRY,
		OP_SUM_MEM_INTO_ACC,
		OP_SUBTRACT,
		OP_COMPARE_ACC_MEM_SKIP,
		OP_SET_CARRY,
		OP_LOAD_POINTER_LONG,
		OP_CLEAR_CARRY,
		OP_LOAD_FLAG_OUTPUTS,
		OP_TEST_FLAG_PIN_ONE,
		OP_TEST_FLAG_PIN_TWO,
		OP_TEST_FLAG_PIN_THREE,
		OP_READ_KEYS,
		OP_TEST_DIGIT_THREE_INPUT,
		OP_TEST_KEY_INPUTS,
		OP_POINTER_DIGIT_TO_OUTPUTS,
		OP_TEST_GENERAL_INPUT,
		OP_MEM_TO_ACC,
		OP_SWAP_ACC_MEM,
		OP_SWAP_ACC_MEM_DEC,
		OP_SWAP_ACC_MEM_INC,
		OP_LOAD_POINTER_SHORT,
		OP_POP_ADDRESS_STACK,
		OP_POP_AND_SKIP,
		OP_CLEAR_MEM_BIT,
		OP_SET_MEM_BIT,
		OP_TEST_MEM_BIT,
		OP_DIGIT_POINTER_TO_ACC,
		OP_TEST_CARRY_SKIP,
		OP_ACC_TO_DIGIT_POINTER,
		OP_ADD_CONSTANT,
		OP_LONG_JUMP_PREFIX,
		OP_STORE_CONSTANT_ADVANCE,
		OP_CALL,
		OP_JUMP,
		OP_OPERAND
	} cpd_op_e;

	typedef struct packed {
		cpd_op_e op;
		logic [1:0] row;
		logic [3:0] digit;
		logic [3:0] konst;
		logic [3:0] mask;
		logic [3:0] page_pair;
		logic [ADDR_W-1:0] addr;
		logic lb_ignore;
	} cpd_dec_s;

	localparam cpd_dec_s DEC_RESET = '{op: OP_NOP, row: 2'h0, digit: 4'h0, konst: 4'h0,
		mask: 4'h0, page_pair: 4'h0, addr: 6'h00, lb_ignore: 1'b0};
endpackage : cpd_pkg
`default_nettype wire

// ---- rtl/cpd_seq_track.sv ----
`timescale 1ns/100ps
`default_nettype none
module cpd_seq_track
	import cpd_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sync_clr,
	// Word stream
	input wire logic word_valid,
	input wire logic two_word,
	input wire logic is_lb,
	// State
	output logic second_word,
	output logic lb_repeat
);
	logic pending_r;
	logic pending_nxt;
	logic lb_prev_r;
	logic lb_prev_nxt;

	always_comb begin
		pending_nxt = pending_r;
		lb_prev_nxt = lb_prev_r;
		if (sync_clr) begin
			pending_nxt = 1'b0;
			lb_prev_nxt = 1'b0;
		end else if (word_valid) begin
			pending_nxt = !pending_r && two_word;
			lb_prev_nxt = !pending_r && is_lb;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pending_r <= 1'b0;
			lb_prev_r <= 1'b0;
		end else begin
			pending_r <= pending_nxt;
			lb_prev_r <= lb_prev_nxt;
		end
	end

	assign second_word = pending_r;
	assign lb_repeat = lb_prev_r;
endmodule : cpd_seq_track
`default_nettype wire

// ---- rtl/cpd_decoder.sv ----
`timescale 1ns/100ps
`default_nettype none
module cpd_decoder
	import cpd_pkg::*;
#(
	parameter logic [3:0] LB_PROG_DIGIT = LB_PROG_DEF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sync_clr,
	// Fetched word
	input wire logic word_valid,
	input wire logic [WORD_W-1:0] word,
	// Decoded result
	output logic dec_valid,
	output cpd_dec_s dec,
	output logic operand_valid,
	output logic [WORD_W-1:0] operand
);
	if (LB_PROG_DIGIT > LB_PROG_MAX) begin : g_bad_digit
		$error("Programmed pointer digit above ten");
	end

	cpd_dec_s dec_r;
	cpd_dec_s dec_nxt;
	cpd_dec_s cur;
	logic dec_valid_r;
	logic dec_valid_nxt;
	logic operand_valid_r;
	logic operand_valid_nxt;
	logic [WORD_W-1:0] operand_r;
	logic [WORD_W-1:0] operand_nxt;
	logic [1:0] top;
	logic [1:0] sel;
	logic [3:0] nib;
	logic [1:0] low;
	logic [1:0] sub;
	logic second_word;
	logic lb_repeat;
	logic two_word;
	logic is_lb;

	// Field split
	assign top = word[TOP_HI:TOP_LO];
	assign sel = word[SEL_HI:SEL_LO];
	assign nib = word[NIB_HI:NIB_LO];
	assign low = word[LOW_HI:LOW_LO];
	assign sub = word[SUB_HI:SUB_LO];

	// Combinational decode of one instruction word
	always_comb begin
		cur = DEC_RESET;
		cur.row = sel;
		cur.konst = nib;
		cur.addr = word[ADDR_W-1:0];
		case (top)
			TOP_REG: begin
				case (nib)
					NIB_ACC: begin
						case (sel)
							SEL_0: cur.op = OP_NOP;
							SEL_1: cur.op = OP_SHOW_ACC_BCD_SEGMENTS;
							SEL_2: cur.op = OP_INVERT_ACCUMULATOR;
							default: cur.op = OP_CLEAR_ACCUMULATOR;
						endcase
					end
					NIB_HOLD: begin
						case (sel)
							SEL_0: cur.op = OP_SWAP_HOLD_WITH_ROW_POINTER;
							SEL_1: cur.op = OP_SHOW_ACC_DECODED_SEGMENTS;
							SEL_2: cur.op = OP_SERIAL_SHIFT_EXCHANGE;
							default: cur.op = OP_SWAP_HOLD_AND_ACC;
						endcase
					end
					NIB_ARITH: begin
						case (sel)
							SEL_0: cur.op = OP_ADD_WITH_CARRY;
							SEL_1: cur.op = OP_SUM_MEM_INTO_ACC;
							SEL_2: cur.op = OP_SUBTRACT;
							default: cur.op = OP_COMPARE_ACC_MEM_SKIP;
						endcase
					end
					NIB_CARRY: begin
						case (sel)
							SEL_0: cur.op = OP_SET_CARRY;
							SEL_1: cur.op = OP_LOAD_POINTER_LONG;
							SEL_2: cur.op = OP_CLEAR_CARRY;
							default: cur.op = OP_LOAD_FLAG_OUTPUTS;
						endcase
					end
					NIB_FLAG: begin
						case (sel)
							SEL_0: cur.op = OP_TEST_FLAG_PIN_ONE;
							SEL_1: cur.op = OP_TEST_FLAG_PIN_TWO;
							SEL_2: cur.op = OP_TEST_FLAG_PIN_THREE;
							default: cur.op = OP_READ_KEYS;
						endcase
					end
					NIB_TEST: begin
						case (sel)
							SEL_0: cur.op = OP_TEST_DIGIT_THREE_INPUT;
							SEL_1: cur.op = OP_TEST_KEY_INPUTS;
							SEL_2: cur.op = OP_POINTER_DIGIT_TO_OUTPUTS;
							default: cur.op = OP_TEST_GENERAL_INPUT;
						endcase
					end
					NIB_MTA: cur.op = OP_MEM_TO_ACC;
					NIB_SWAP: cur.op = OP_SWAP_ACC_MEM;
					NIB_SWAP_DEC: cur.op = OP_SWAP_ACC_MEM_DEC;
					NIB_SWAP_INC: cur.op = OP_SWAP_ACC_MEM_INC;
					default: begin
						cur.op = OP_LOAD_POINTER_SHORT;
						cur.digit = (nib == NIB_LB_PROG) ? LB_PROG_DIGIT : nib;
					end
				endcase
			end
			TOP_BIT: begin
				case (sel)
					SEL_0: begin
						case (sub)
							SEL_0: begin
								case (low)
									SEL_0: cur.op = OP_POP_ADDRESS_STACK;
									SEL_1: cur.op = OP_POP_AND_SKIP;
									SEL_2: begin
										cur.op = OP_CLEAR_MEM_BIT;
										cur.mask = MASK_8;
									end
									default: cur.op = OP_DIGIT_POINTER_TO_ACC;
								endcase
							end
							SEL_1: begin
								cur.op = OP_TEST_MEM_BIT;
								case (low)
									SEL_0: cur.mask = MASK_1;
									SEL_1: cur.mask = MASK_2;
									SEL_2: cur.mask = MASK_4;
									default: cur.mask = MASK_8;
								endcase
							end
							SEL_2: begin
								case (low)
									SEL_0: begin
										cur.op = OP_CLEAR_MEM_BIT;
										cur.mask = MASK_1;
									end
									SEL_1: begin
										cur.op = OP_SET_MEM_BIT;
										cur.mask = MASK_1;
									end
									SEL_2: begin
										cur.op = OP_SET_MEM_BIT;
										cur.mask = MASK_8;
									end
									default: begin
										cur.op = OP_CLEAR_MEM_BIT;
										cur.mask = MASK_4;
									end
								endcase
							end
							default: begin
								case (low)
									SEL_0: begin
										cur.op = OP_CLEAR_MEM_BIT;
										cur.mask = MASK_2;
									end
									SEL_1: cur.op = OP_TEST_CARRY_SKIP;
									SEL_2: begin
										cur.op = OP_SET_MEM_BIT;
										cur.mask = MASK_2;
									end
									default: begin
										cur.op = OP_SET_MEM_BIT;
										cur.mask = MASK_4;
									end
								endcase
							end
						endcase
					end
					SEL_1: begin
						if (nib == ZERO_NIB) begin
							cur.op = OP_ACC_TO_DIGIT_POINTER;
						end else begin
							cur.op = OP_ADD_CONSTANT;
						end
					end
					SEL_2: begin
						cur.op = OP_LONG_JUMP_PREFIX;
						cur.page_pair = ~nib;
					end
					default: cur.op = OP_STORE_CONSTANT_ADVANCE;
				endcase
			end
			TOP_CALL: cur.op = OP_CALL;
			default: cur.op = OP_JUMP;
		endcase
	end

	assign two_word = (cur.op == OP_LONG_JUMP_PREFIX) || (cur.op == OP_LOAD_POINTER_LONG) ||
		(cur.op == OP_LOAD_FLAG_OUTPUTS);
	assign is_lb = (cur.op == OP_LOAD_POINTER_SHORT);

	cpd_seq_track u_seq (
		.clk(clk),
		.rst_n(rst_n),
		.sync_clr(sync_clr),
		.word_valid(word_valid),
		.two_word(two_word),
		.is_lb(is_lb),
		.second_word(second_word),
		.lb_repeat(lb_repeat)
	);

	// Output register next values
	always_comb begin
		dec_nxt = DEC_RESET;
		dec_valid_nxt = 1'b0;
		operand_valid_nxt = 1'b0;
		operand_nxt = operand_r;
		if (sync_clr) begin
			dec_nxt = DEC_RESET;
		end else if (word_valid && second_word) begin
			dec_nxt.op = OP_OPERAND;
			dec_valid_nxt = 1'b1;
			operand_valid_nxt = 1'b1;
			operand_nxt = word;
		end else if (word_valid) begin
			dec_nxt = cur;
			dec_nxt.lb_ignore = is_lb && lb_repeat;
			dec_valid_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dec_r <= DEC_RESET;
			dec_valid_r <= 1'b0;
			operand_valid_r <= 1'b0;
			operand_r <= 8'h00;
		end else begin
			dec_r <= dec_nxt;
			dec_valid_r <= dec_valid_nxt;
			operand_valid_r <= operand_valid_nxt;
			operand_r <= operand_nxt;
		end
	end

	assign dec = dec_r;
	assign dec_valid = dec_valid_r;
	assign operand_valid = operand_valid_r;
	assign operand = operand_r;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_instr;
		word_valid && !second_word && !sync_clr;
	endsequence

	sequence s_two_word_head;
		s_instr ##0 two_word;
	endsequence

	chk_call_addr: assert property (
		s_instr ##0 (top == TOP_CALL) |=> dec_r.op == OP_CALL && dec_r.addr == $past(word[5:0]))
		else $error("Call decode or address wrong");

	chk_jump_addr: assert property (
		s_instr ##0 (top == TOP_JUMP) |=> dec_r.op == OP_JUMP && dec_r.addr == $past(word[5:0]))
		else $error("Jump decode or address wrong");

	chk_operand_word: assert property (
		s_two_word_head ##1 (word_valid && !sync_clr)
		|=> dec_r.op == OP_OPERAND && operand_valid_r && operand_r == $past(word))
		else $error("Second word was decoded as instruction");

	chk_lb_repeat: assert property (
		(s_instr ##0 is_lb) ##1 (s_instr ##0 is_lb) |=> dec_r.lb_ignore)
		else $error("Repeated short pointer load not flagged");

	chk_lb_first: assert property (
		(s_instr ##0 !is_lb) ##1 (s_instr ##0 is_lb) |=> !dec_r.lb_ignore)
		else $error("First short pointer load flagged");

	chk_sync_nop: assert property (
		sync_clr |=> dec_r.op == OP_NOP && !dec_valid_r && !operand_valid_r)
		else $error("Synchronous clear did not force nop");

	chk_lb_digit: assert property (
		s_instr ##0 (top == TOP_REG) && (nib >= NIB_LB_PROG)
		|=> dec_r.op == OP_LOAD_POINTER_SHORT && dec_r.row == $past(sel)
		&& dec_r.digit == (($past(nib) == NIB_LB_PROG) ? LB_PROG_DIGIT : $past(nib)))
		else $error("Short pointer digit wrong");

	chk_add_const: assert property (
		s_instr ##0 (word[7:4] == 4'h5) && (nib != ZERO_NIB)
		|=> dec_r.op == OP_ADD_CONSTANT && dec_r.konst == $past(nib))
		else $error("Add constant decode wrong");

	chk_page_pair: assert property (
		s_instr ##0 (word[7:4] == 4'h6)
		|=> dec_r.op == OP_LONG_JUMP_PREFIX && dec_r.page_pair == ~$past(nib))
		else $error("Page pair select wrong");

	chk_test_mask: assert property (
		s_instr ##0 (word[7:2] == 6'h11)
		|=> dec_r.op == OP_TEST_MEM_BIT && dec_r.mask == (4'h1 << $past(low)))
		else $error("Test bit mask wrong");

	chk_nop_word: assert property (
		s_instr ##0 (word == 8'h00) |=> dec_r.op == OP_NOP && dec_valid_r)
		else $error("Zero word not decoded as nop");

	chk_row_field: assert property (
		s_instr ##0 (top == TOP_REG) && (nib >= NIB_MTA) && (nib <= NIB_SWAP_INC)
		|=> dec_r.row == $past(sel) && dec_r.op != OP_NOP)
		else $error("Memory op row field wrong");
endmodule : cpd_decoder
`default_nettype wire

// ---- test/cpd_rom_feed.sv ----
`timescale 1ns/100ps
`default_nettype none
module cpd_rom_feed
	import cpd_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Feed control
	input wire logic [1:0] mode,
	output logic done,
	// Fetched word
	output logic word_valid,
	output logic [WORD_W-1:0] word
);
	logic [8:0] idx_r;
	logic ph_r;

	// Modes: 0 idle, 1 sweep of all codes, 2 dense random, 3 stalling random
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idx_r <= 9'h000;
			ph_r <= 1'b0;
			word_valid <= 1'b0;
			word <= 8'h00;
		end else if (mode == 2'h1 && !idx_r[8]) begin
			word_valid <= 1'b1;
			word <= ph_r ? 8'h00 : idx_r[7:0]; // Filler word may be taken as operand
			idx_r <= idx_r + {8'h00, ph_r};
			ph_r <= !ph_r;
		end else if (mode[1] && (!mode[0] || $urandom_range(2) == 0)) begin
			word_valid <= 1'b1;
			word <= ($urandom_range(3) == 0) ? // Dense short pointer loads
				{2'h0, 2'($urandom), 4'($urandom_range(15, 10))} : 8'($urandom);
		end else begin
			word_valid <= 1'b0;
			word <= ~word; // No stale value while idle
		end
	end

	assign done = idx_r[8];
endmodule : cpd_rom_feed
`default_nettype wire

// ---- test/calc_proc_opcode_decoder_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module calc_proc_opcode_decoder_tb
	import cpd_pkg::*;
;
	localparam logic [3:0] PROG = 4'h7;
	logic clk, rst_n, sync_clr, word_valid, dec_valid, operand_valid, done;
	logic [WORD_W-1:0] word, operand, eopnd;
	logic [1:0] mode;
	cpd_dec_s dec, e;
	logic ev, eov, pend, plb, full, lbnow;
	logic [4:0] cr;
	int fail_count, n_checks, cyc;

	cpd_decoder #(.LB_PROG_DIGIT(PROG)) u_dut (.clk(clk), .rst_n(rst_n), .sync_clr(sync_clr),
		.word_valid(word_valid), .word(word), .dec_valid(dec_valid), .dec(dec),
		.operand_valid(operand_valid), .operand(operand));
	cpd_rom_feed u_feed (.clk(clk), .rst_n(rst_n), .mode(mode), .done(done),
		.word_valid(word_valid), .word(word));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Expected decode; c: row, digit, konst, page pair, address
	function automatic void decode(input logic [7:0] w, output cpd_dec_s d, output logic [4:0] c);
		d = DEC_RESET;
		c = 5'h00;
		d.row = w[5:4];
		d.digit = w[3:0];
		d.konst = w[3:0];
		d.page_pair = ~w[3:0];
		d.addr = w[5:0];
		case (w[7:6])
			2'h0: begin
				c[0] = (w[3:0] > 4'h5);
				if (w[3:0] < 4'h6) d.op = cpd_op_e'({w[3:0], w[5:4]});
				else if (w[3:0] < 4'ha) d.op = cpd_op_e'(6'(OP_MEM_TO_ACC + w[3:0] - 6));
				else begin
					d.op = OP_LOAD_POINTER_SHORT;
					c[1] = 1'b1;
					if (w[3:0] == 4'ha) d.digit = PROG;
				end
			end
			2'h1: case (w[5:4])
				2'h0: begin
					case (w[3:0])
						4'h0: d.op = OP_POP_ADDRESS_STACK;
						4'h1: d.op = OP_POP_AND_SKIP;
						4'h3: d.op = OP_DIGIT_POINTER_TO_ACC;
						4'hd: d.op = OP_TEST_CARRY_SKIP;
						4'h4, 4'h5, 4'h6, 4'h7: d.op = OP_TEST_MEM_BIT;
						4'h9, 4'ha, 4'he, 4'hf: d.op = OP_SET_MEM_BIT;
						default: d.op = OP_CLEAR_MEM_BIT;
					endcase
					case (w[3:0])
						4'h2, 4'ha: d.mask = 4'h8;
						4'h8, 4'h9: d.mask = 4'h1;
						4'hb, 4'hf: d.mask = 4'h4;
						4'hc, 4'he: d.mask = 4'h2;
						4'h4, 4'h5, 4'h6, 4'h7: d.mask = 4'h1 << w[1:0];
						default: d.mask = 4'h0;
					endcase
				end
				2'h1: begin
					d.op = (w[3:0] == 4'h0) ? OP_ACC_TO_DIGIT_POINTER : OP_ADD_CONSTANT;
					c[2] = (w[3:0] != 4'h0);
				end
				2'h2: begin
					d.op = OP_LONG_JUMP_PREFIX;
					c[3] = 1'b1;
				end
				default: begin
					d.op = OP_STORE_CONSTANT_ADVANCE;
					c[2] = 1'b1;
				end
			endcase
			2'h2: begin
				d.op = OP_CALL;
				c[4] = 1'b1;
			end
			default: begin
				d.op = OP_JUMP;
				c[4] = 1'b1;
			end
		endcase
	endfunction : decode

	// Reference model, one accepted word per edge
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n || sync_clr || !word_valid) begin
			e = DEC_RESET;
			ev = 1'b0;
			eov = 1'b0;
			full = 1'b1;
			cr = 5'h00;
			if (!rst_n || sync_clr) pend = 1'b0;
			if (!rst_n || sync_clr) plb = 1'b0;
			if (!rst_n) eopnd = 8'h00;
		end else if (pend) begin
			e = DEC_RESET;
			e.op = OP_OPERAND;
			ev = 1'b1;
			eov = 1'b1;
			full = 1'b0;
			cr = 5'h00;
			eopnd = word;
			pend = 1'b0;
			plb = 1'b0;
		end else begin
			decode(word, e, cr);
			ev = 1'b1;
			eov = 1'b0;
			full = 1'b0;
			lbnow = (e.op == OP_LOAD_POINTER_SHORT);
			e.lb_ignore = lbnow && plb;
			plb = lbnow;
			pend = e.op inside {OP_LONG_JUMP_PREFIX, OP_LOAD_POINTER_LONG, OP_LOAD_FLAG_OUTPUTS};
		end
	end

	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		n_checks++;
		if (g !== x) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, x, g);
		end
	endtask : chk

	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	always @(negedge clk) begin
		chk("dec_valid", 32'(ev), 32'(dec_valid));
		chk("operand_valid", 32'(eov), 32'(operand_valid));
		chk("op", 32'(e.op), 32'(dec.op));
		chk("mask", 32'(e.mask), 32'(dec.mask));
		chk("lb_ignore", 32'(e.lb_ignore), 32'(dec.lb_ignore));
		if (full) chk("idle", 32'(e), 32'(dec));
		if (cr[0]) chk("row", 32'(e.row), 32'(dec.row));
		if (cr[1]) chk("digit", 32'(e.digit), 32'(dec.digit));
		if (cr[2]) chk("konst", 32'(e.konst), 32'(dec.konst));
		if (cr[3]) chk("page_pair", 32'(e.page_pair), 32'(dec.page_pair));
		if (cr[4]) chk("addr", 32'(e.addr), 32'(dec.addr));
		if (eov) chk("operand", 32'(eopnd), 32'(operand));
		cyc++;
		if (cyc > 12000) begin
			fail_count++;
			$display("[ERR] cycle_limit expected 12000 seen %0d", cyc);
			end_sim;
		end
	end

	initial begin
		rst_n = 1'b0;
		sync_clr = 1'b0;
		mode = 2'h0;
		fail_count = 0;
		n_checks = 0;
		cyc = 0;
		void'($urandom(61));
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		mode <= 2'h1;
		repeat (600) begin
			@(posedge clk);
			if (done) break;
		end
		chk("sweep_done", 32'h1, 32'(done));
		mode <= 2'h2;
		repeat (3000) begin
			@(posedge clk);
			sync_clr <= ($urandom_range(63) == 0);
		end
		@(posedge clk);
		sync_clr <= 1'b0;
		mode <= 2'h3;
		repeat (2000) @(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (500) @(posedge clk);
		mode <= 2'h0;
		repeat (5) @(posedge clk);
		end_sim;
	end
endmodule : calc_proc_opcode_decoder_tb
`default_nettype wire
